// [rtl/pmm_pkg.sv]
// Constants and types for the port mode multiplexer
// Contract
// - Address bit out on ctl with dir or OE term
// - Non-multiplexed bus gives A7-A0 on Port B
// - Address output only on Ports A and B
// - Nibble address assignment follows host bus type
// - Driver enable is direction OR product term
// - Data port mode ties Port A to data
// - Upper address inputs latched on address strobe
// - Decode inputs treated as address inputs
// - Mode register bit 7 makes Port A buffer
// - Buffer floats when no select is active
// - Test pins enabled by any of three
// - Control zero is I/O, one is address on bits the bus type assigns
package pmm_pkg;
    localparam int PORT_W = 8;
    localparam int PORTD_W = 3;
    localparam int PERIPH_BIT = 7;
    localparam logic [7:0] CTL_RESET = 8'h00;
    localparam logic [7:0] DIR_RESET = 8'h00;
    localparam logic [7:0] ZERO8 = 8'h00;
    localparam logic [7:0] ONES8 = 8'hFF;
    localparam logic [2:0] ZERO3 = 3'h0;
    typedef enum logic [1:0] {
        PMM_BUS_MUX8 = 2'b00,
        PMM_BUS_XA8 = 2'b01,
        PMM_BUS_PAGE = 2'b10,
        PMM_BUS_NONMUX8 = 2'b11
    } pmm_bus_t;
endpackage

// [rtl/pmm_port_mode_mux.sv]
// Port mode multiplexer for Ports A to D
`timescale 1ns/1ps
module pmm_port_mode_mux (
    // Clock and reset
    input wire logic clk,
    input wire logic reset,
    // Static configuration
    input wire logic [1:0] bus_type,
    input wire logic data_port_en,
    input wire logic test_cfg_en,
    input wire logic test_bit_en,
    // Run-time registers
    input wire logic [7:0] mode_select_register,
    input wire logic [7:0] ctl_a,
    input wire logic [7:0] ctl_b,
    input wire logic [7:0] dir_a,
    input wire logic [7:0] dir_b,
    input wire logic [7:0] dir_c,
    input wire logic [2:0] dir_d,
    input wire logic [7:0] dout_a,
    input wire logic [7:0] dout_b,
    input wire logic [7:0] dout_c,
    input wire logic [2:0] dout_d,
    // Logic array terms
    input wire logic [7:0] oe_term_a,
    input wire logic [7:0] oe_term_b,
    input wire logic [7:0] oe_term_c,
    input wire logic [2:0] oe_term_d,
    input wire logic periph_select_zero,
    input wire logic periph_select_one,
    input wire logic [7:0] decode_use_a,
    // Host bus
    input wire logic [15:0] host_addr,
    input wire logic addr_latch_strobe,
    input wire logic host_rd,
    input wire logic host_wr,
    input wire logic [7:0] host_data_in,
    output logic [7:0] host_data_out,
    output logic host_data_oe,
    // Port pins
    input wire logic [7:0] pa_in,
    input wire logic [7:0] pb_in,
    input wire logic [7:0] pc_in,
    input wire logic [2:0] pd_in,
    input wire logic test_pin_select,
    output logic [7:0] pa_out,
    output logic [7:0] pa_oe,
    output logic [7:0] pb_out,
    output logic [7:0] pb_oe,
    output logic [7:0] pc_out,
    output logic [7:0] pc_oe,
    output logic [2:0] pd_out,
    output logic [2:0] pd_oe,
    // Status
    output logic [7:0] latched_addr_in_a,
    output logic [7:0] latched_addr_in_b,
    output logic [7:0] latched_addr_in_c,
    output logic [2:0] latched_addr_in_d,
    output logic [7:0] addr_input_mask,
    output logic test_pins_en
);
    // Pin synchronisers
    logic [7:0] pa_m, pa_s, pb_m, pb_s, pc_m, pc_s;
    logic [2:0] pd_m, pd_s;
    logic [3:0] ctl_m, ctl_s;
    logic [15:0] addr_m, addr_s;
    logic [7:0] hd_m, hd_s;
    logic strobe_d;
    logic [15:0] lat_addr;
    logic [7:0] next_pa_out, next_pa_oe, next_pb_out, next_pb_oe, next_pc_out, next_pc_oe;
    logic [2:0] next_pd_out, next_pd_oe;
    logic [7:0] next_hdo;
    logic next_hdoe;
    logic [7:0] next_lia, next_lib, next_lic;
    logic [2:0] next_lid;
    logic [15:0] next_lat;
    logic [7:0] addr_a, addr_b, avail_a, avail_b;
    logic strobe_rise, periph_on, psel, next_test;
    pmm_pkg::pmm_bus_t bt;

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            pa_m <= pmm_pkg::ZERO8;
            pa_s <= pmm_pkg::ZERO8;
            pb_m <= pmm_pkg::ZERO8;
            pb_s <= pmm_pkg::ZERO8;
            pc_m <= pmm_pkg::ZERO8;
            pc_s <= pmm_pkg::ZERO8;
            pd_m <= pmm_pkg::ZERO3;
            pd_s <= pmm_pkg::ZERO3;
            ctl_m <= 4'h0;
            ctl_s <= 4'h0;
            addr_m <= 16'h0000;
            addr_s <= 16'h0000;
            hd_m <= pmm_pkg::ZERO8;
            hd_s <= pmm_pkg::ZERO8;
        end else begin
            pa_m <= pa_in;
            pa_s <= pa_m;
            pb_m <= pb_in;
            pb_s <= pb_m;
            pc_m <= pc_in;
            pc_s <= pc_m;
            pd_m <= pd_in;
            pd_s <= pd_m;
            ctl_m <= {addr_latch_strobe, host_rd, host_wr, test_pin_select};
            ctl_s <= ctl_m;
            addr_m <= host_addr;
            addr_s <= addr_m;
            hd_m <= host_data_in;
            hd_s <= hd_m;
        end
    end

    assign bt = pmm_pkg::pmm_bus_t'(bus_type);
    assign strobe_rise = ctl_s[3] & ~strobe_d;
    assign periph_on = mode_select_register[pmm_pkg::PERIPH_BIT];
    assign psel = periph_select_zero | periph_select_one;

    // Address nibble assignment per bus type
    always_comb begin
        addr_a = pmm_pkg::ZERO8;
        addr_b = pmm_pkg::ZERO8;
        avail_a = pmm_pkg::ZERO8;
        avail_b = pmm_pkg::ZERO8;
        case (bt)
            pmm_pkg::PMM_BUS_MUX8: begin
                addr_a = lat_addr[7:0];
                addr_b = lat_addr[7:0];
                avail_a = pmm_pkg::ONES8;
                avail_b = pmm_pkg::ONES8;
            end
            pmm_pkg::PMM_BUS_XA8: begin
                addr_a = {lat_addr[7:4], 4'h0};
                addr_b = {4'h0, lat_addr[11:8]};
                avail_a = 8'hF0;
                avail_b = 8'h0F;
            end
            pmm_pkg::PMM_BUS_PAGE: begin
                addr_b = lat_addr[15:8];
                avail_b = pmm_pkg::ONES8;
            end
            default: begin
                addr_b = lat_addr[7:0];
                avail_b = pmm_pkg::ONES8;
            end
        endcase
    end

    always_comb begin
        next_lat = lat_addr;
        next_lia = latched_addr_in_a;
        next_lib = latched_addr_in_b;
        next_lic = latched_addr_in_c;
        next_lid = latched_addr_in_d;
        if (strobe_rise) begin
            next_lat = addr_s;
            next_lia = pa_s;
            next_lib = pb_s;
            next_lic = pc_s;
            next_lid = pd_s;
        end
        // Port A: ctl 0 is I/O, ctl 1 with dir or term is address on bits the bus type assigns
        next_pa_out = dout_a;
        next_pa_oe = dir_a | oe_term_a;
        for (int i = 0; i < pmm_pkg::PORT_W; i++) begin
            if (ctl_a[i] & avail_a[i]) begin
                next_pa_out[i] = addr_a[i];
            end
        end
        next_pb_out = dout_b;
        next_pb_oe = dir_b | oe_term_b;
        for (int i = 0; i < pmm_pkg::PORT_W; i++) begin
            if (ctl_b[i] & avail_b[i]) begin
                next_pb_out[i] = addr_b[i];
            end
        end
        // Ports C and D stay under direction and data out
        next_pc_out = dout_c;
        next_pc_oe = dir_c | oe_term_c;
        next_pd_out = dout_d;
        next_pd_oe = dir_d | oe_term_d;
        next_hdo = pmm_pkg::ZERO8;
        next_hdoe = 1'b0;
        if (data_port_en) begin
            next_pa_out = pmm_pkg::ZERO8;
            next_pa_oe = pmm_pkg::ZERO8;
            next_hdo = pa_s;
            next_hdoe = ctl_s[2];
        end else if (periph_on) begin
            next_pa_out = hd_s;
            next_pa_oe = pmm_pkg::ZERO8;
            if (psel & ctl_s[1]) begin
                next_pa_oe = pmm_pkg::ONES8;
            end
            if (psel & ctl_s[2]) begin
                next_hdo = pa_s;
                next_hdoe = 1'b1;
            end
        end
        next_test = ctl_s[0] | test_cfg_en | test_bit_en;
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            strobe_d <= 1'b0;
            lat_addr <= 16'h0000;
            latched_addr_in_a <= pmm_pkg::ZERO8;
            latched_addr_in_b <= pmm_pkg::ZERO8;
            latched_addr_in_c <= pmm_pkg::ZERO8;
            latched_addr_in_d <= pmm_pkg::ZERO3;
            pa_out <= pmm_pkg::ZERO8;
            pa_oe <= pmm_pkg::ZERO8;
            pb_out <= pmm_pkg::ZERO8;
            pb_oe <= pmm_pkg::ZERO8;
            pc_out <= pmm_pkg::ZERO8;
            pc_oe <= pmm_pkg::ZERO8;
            pd_out <= pmm_pkg::ZERO3;
            pd_oe <= pmm_pkg::ZERO3;
            host_data_out <= pmm_pkg::ZERO8;
            host_data_oe <= 1'b0;
            addr_input_mask <= pmm_pkg::ZERO8;
            test_pins_en <= 1'b0;
        end else begin
            strobe_d <= ctl_s[3];
            lat_addr <= next_lat;
            latched_addr_in_a <= next_lia;
            latched_addr_in_b <= next_lib;
            latched_addr_in_c <= next_lic;
            latched_addr_in_d <= next_lid;
            pa_out <= next_pa_out;
            pa_oe <= next_pa_oe;
            pb_out <= next_pb_out;
            pb_oe <= next_pb_oe;
            pc_out <= next_pc_out;
            pc_oe <= next_pc_oe;
            pd_out <= next_pd_out;
            pd_oe <= next_pd_oe;
            host_data_out <= next_hdo;
            host_data_oe <= next_hdoe;
            addr_input_mask <= decode_use_a;
            test_pins_en <= next_test;
        end
    end

    // Assertions
    property p_oe_or;
        @(posedge clk) disable iff (reset)
        (!data_port_en && !periph_on) |=> (pa_oe == $past(dir_a | oe_term_a));
    endproperty
    a_oe_or: assert property (p_oe_or) else $error("port A enable not dir or term");

    property p_float;
        @(posedge clk) disable iff (reset)
        (periph_on && !data_port_en && !psel) |=> (pa_oe == pmm_pkg::ZERO8);
    endproperty
    a_float: assert property (p_float) else $error("buffer drives without select");

    property p_cd;
        @(posedge clk) disable iff (reset)
        1'b1 |=> (pc_out == $past(dout_c) && pd_out == $past(dout_d));
    endproperty
    a_cd: assert property (p_cd) else $error("port C or D not data out");

    property p_dport;
        @(posedge clk) disable iff (reset)
        data_port_en |=> (pa_oe == pmm_pkg::ZERO8);
    endproperty
    a_dport: assert property (p_dport) else $error("data port drives pins");

    property p_ctl0;
        @(posedge clk) disable iff (reset)
        (!data_port_en && !periph_on && ctl_b == pmm_pkg::CTL_RESET) |=> (pb_out == $past(dout_b));
    endproperty
    a_ctl0: assert property (p_ctl0) else $error("port B not I/O with ctl zero");

    property p_test;
        @(posedge clk) disable iff (reset)
        (test_cfg_en || test_bit_en) |=> test_pins_en;
    endproperty
    a_test: assert property (p_test) else $error("test pins not enabled");

    sequence s_strobe;
        ctl_s[3] && !strobe_d;
    endsequence
    property p_latch;
        @(posedge clk) disable iff (reset)
        s_strobe |=> (latched_addr_in_c == $past(pc_s));
    endproperty
    a_latch: assert property (p_latch) else $error("address input not latched");

    property p_nonmux;
        @(posedge clk) disable iff (reset)
        (bt == pmm_pkg::PMM_BUS_NONMUX8 && !data_port_en && !periph_on && ctl_a == pmm_pkg::ONES8)
            |=> (pa_out == $past(dout_a));
    endproperty
    a_nonmux: assert property (p_nonmux) else $error("port A carries address on non-mux bus");

    property p_addr;
        @(posedge clk) disable iff (reset)
        (bt == pmm_pkg::PMM_BUS_PAGE && !data_port_en && !periph_on && ctl_b == pmm_pkg::ONES8)
            |=> (pb_out == $past(lat_addr[15:8]));
    endproperty
    a_addr: assert property (p_addr) else $error("port B lacks high address byte");
endmodule

// [tb/pmm_host_model.sv]
// Host bus model: address strobe, reads and writes
`timescale 1ns/1ps
module pmm_host_model (
    // Clock
    input wire logic clk,
    // Host bus
    output logic [15:0] host_addr,
    output logic addr_latch_strobe,
    output logic host_rd,
    output logic host_wr,
    output logic [7:0] host_data_in
);
    initial begin
        host_addr = 16'h0000;
        addr_latch_strobe = 1'b0;
        host_rd = 1'b0;
        host_wr = 1'b0;
        host_data_in = 8'h00;
    end
    // Address phase with a strobe pulse
    task automatic latch(input logic [15:0] a);
        @(posedge clk);
        host_addr <= a;
        addr_latch_strobe <= 1'b1;
        repeat (4) @(posedge clk);
        addr_latch_strobe <= 1'b0;
        repeat (4) @(posedge clk);
    endtask
    // Start a read or write cycle
    task automatic start(input logic rd, input logic wr, input logic [7:0] d);
        @(posedge clk);
        host_rd <= rd;
        host_wr <= wr;
        host_data_in <= d;
    endtask
    // End of cycle; released data bus shows the inverse
    task automatic stop();
        @(posedge clk);
        host_rd <= 1'b0;
        host_wr <= 1'b0;
        host_data_in <= ~host_data_in;
    endtask
endmodule

// [tb/testbench.sv]
// Self-checking bench for the port mode multiplexer
`timescale 1ns/1ps
module testbench;
    logic clk = 1'b0;
    logic reset = 1'b1;
    logic [1:0] bus_type = 2'h0;
    logic data_port_en = 1'b0, test_cfg_en = 1'b0, test_bit_en = 1'b0, test_pin_select = 1'b0;
    logic periph_select_zero = 1'b0, periph_select_one = 1'b0;
    logic [7:0] mode_select_register = 8'h00, ctl_a = 8'h00, ctl_b = 8'h00, dir_a = 8'h00, dir_b = 8'h00;
    logic [7:0] dir_c = 8'h00, dout_a = 8'h00, dout_b = 8'h00, dout_c = 8'h00, oe_term_a = 8'h00;
    logic [7:0] oe_term_b = 8'h00, oe_term_c = 8'h00, decode_use_a = 8'h00;
    logic [7:0] pa_in = 8'h00, pb_in = 8'h00, pc_in = 8'h00;
    logic [2:0] dir_d = 3'h0, dout_d = 3'h0, oe_term_d = 3'h0, pd_in = 3'h0;
    logic [15:0] host_addr;
    logic addr_latch_strobe, host_rd, host_wr, host_data_oe, test_pins_en;
    logic [7:0] host_data_in, host_data_out, pa_out, pa_oe, pb_out, pb_oe, pc_out, pc_oe;
    logic [7:0] latched_addr_in_a, latched_addr_in_b, latched_addr_in_c, addr_input_mask;
    logic [2:0] pd_out, pd_oe, latched_addr_in_d;
    logic [7:0] exp_a [4] = '{8'hC3, 8'hC6, 8'h66, 8'h66};
    logic [7:0] exp_b [4] = '{8'hC3, 8'h95, 8'hA5, 8'hC3};
    int fails = 0;
    int cmp_count = 0;
    always #25 clk = ~clk;
    pmm_host_model u_pmm_host_model (.clk, .host_addr, .addr_latch_strobe, .host_rd, .host_wr, .host_data_in);
    pmm_port_mode_mux u_pmm_port_mode_mux (.clk, .reset, .bus_type, .data_port_en, .test_cfg_en, .test_bit_en,
        .mode_select_register, .ctl_a, .ctl_b, .dir_a, .dir_b, .dir_c, .dir_d, .dout_a, .dout_b, .dout_c,
        .dout_d, .oe_term_a, .oe_term_b, .oe_term_c, .oe_term_d, .periph_select_zero, .periph_select_one,
        .decode_use_a, .host_addr, .addr_latch_strobe, .host_rd, .host_wr, .host_data_in, .host_data_out,
        .host_data_oe, .pa_in, .pb_in, .pc_in, .pd_in, .test_pin_select, .pa_out, .pa_oe, .pb_out, .pb_oe,
        .pc_out, .pc_oe, .pd_out, .pd_oe, .latched_addr_in_a, .latched_addr_in_b, .latched_addr_in_c,
        .latched_addr_in_d, .addr_input_mask, .test_pins_en);
    task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            fails++;
            $display("[FAIL] %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic results();
        $display("Comparisons %0d, mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    task automatic settle();
        repeat (6) @(posedge clk);
        #1;
    endtask
    // Address out per bus type, then direction OR product term
    task automatic t_addr_out();
        u_pmm_host_model.latch(16'hA5C3);
        @(posedge clk);
        {ctl_a, ctl_b, dir_a, dir_b} <= 32'hFFFFFFFF;
        {dout_a, dout_b} <= 16'h6699;
        for (int i = 0; i < 4; i++) begin
            @(posedge clk);
            bus_type <= 2'(i);
            settle();
            check("pa_out", pa_out, exp_a[i]);
            check("pb_out", pb_out, exp_b[i]);
            check("pb_oe", pb_oe, 8'hFF);
        end
        @(posedge clk);
        ctl_b <= 8'h00;
        {dir_a, oe_term_a} <= 16'h00FF;
        bus_type <= 2'h0;
        settle();
        check("pb_out io", pb_out, 8'h99);
        check("pa_out oe", pa_out, 8'hC3);
        check("pa_oe term", pa_oe, 8'hFF);
    endtask
    // Ports C and D stay on direction and data out
    task automatic t_port_cd();
        @(posedge clk);
        dir_c <= 8'hFF;
        dout_c <= 8'h5A;
        dir_d <= 3'h7;
        dout_d <= 3'h5;
        settle();
        check("pc_out", pc_out, 8'h5A);
        check("pc_oe", pc_oe, 8'hFF);
        check("pd_out", pd_out, 3'h5);
        check("pd_oe", pd_oe, 3'h7);
    endtask
    // Peripheral buffer mode, both directions
    task automatic t_periph();
        @(posedge clk);
        {ctl_a, oe_term_a} <= 16'h0000;
        mode_select_register <= 8'h80;
        pa_in <= 8'h3C;
        u_pmm_host_model.start(1'b0, 1'b1, 8'h5A);
        settle();
        check("pa_oe nosel", pa_oe, 8'h00);
        @(posedge clk);
        periph_select_zero <= 1'b1;
        settle();
        check("pa_out wr", pa_out, 8'h5A);
        check("pa_oe wr", pa_oe, 8'hFF);
        u_pmm_host_model.stop();
        u_pmm_host_model.start(1'b1, 1'b0, 8'h00);
        {periph_select_zero, periph_select_one} <= 2'b01;
        settle();
        check("host_data_out", host_data_out, 8'h3C);
        check("host_data_oe", host_data_oe, 1'b1);
        check("pa_oe rd", pa_oe, 8'h00);
        @(posedge clk);
        data_port_en <= 1'b1;
        settle();
        check("dport oe rd", host_data_oe, 1'b1);
        check("dport data", host_data_out, 8'h3C);
        check("dport pa_oe", pa_oe, 8'h00);
        u_pmm_host_model.stop();
        settle();
        check("dport oe idle", host_data_oe, 1'b0);
    endtask
    // Address input latching and decode mask
    task automatic t_addr_in();
        @(posedge clk);
        pa_in <= 8'h96;
        pb_in <= 8'h69;
        pc_in <= 8'hA5;
        pd_in <= 3'h6;
        decode_use_a <= 8'h0F;
        u_pmm_host_model.latch(16'h1234);
        pa_in <= 8'h00;
        pb_in <= 8'h00;
        pc_in <= 8'h00;
        pd_in <= 3'h0;
        settle();
        check("latch a", latched_addr_in_a, 8'h96);
        check("latch b", latched_addr_in_b, 8'h69);
        check("latch c", latched_addr_in_c, 8'hA5);
        check("latch d", latched_addr_in_d, 3'h6);
        check("mask", addr_input_mask, 8'h0F);
    endtask
    // Test pins: each of three enables alone, then none
    task automatic t_test();
        for (int i = 0; i < 4; i++) begin
            @(posedge clk);
            {test_pin_select, test_cfg_en, test_bit_en} <= 3'(4 >> i);
            settle();
            check("test_pins_en", test_pins_en, 1'(i < 3));
        end
    endtask
    initial begin
        repeat (10) @(posedge clk);
        #1;
        check("pa_oe rst", pa_oe, 8'h00);
        check("pb_oe rst", pb_oe, 8'h00);
        @(posedge clk);
        reset <= 1'b0;
        t_addr_out();
        t_port_cd();
        t_periph();
        t_addr_in();
        t_test();
        results();
    end
    initial begin
        repeat (20000) @(posedge clk);
        fails++;
        results();
    end
endmodule
